/* src/counter_command_decoder.sv */
/*
   Command decoder for a five-counter timing controller: decodes the 8-bit
   command byte into per-counter strobes, master-mode bits and the data
   pointer, and holds the five counters themselves.
   Assumes commands arrive as a one-cycle write strobe synchronous to
   ref_clk, and that the full counter-mode decode happens elsewhere and
   arrives here as per-counter reload class and flags.
*/
// Contract
// (RULE1) Mask bits 0-4 select counters 1-5
// (RULE2) Arm enables counting; zero bit ignored
// (RULE3) Load copies load or hold register
// (RULE4) Load before terminal count enters it
// (RULE5) Load in terminal count ends it
// (RULE6) Disarmed load reloads from load register
// (RULE7) Gate level picks source in gate modes
// (RULE8) Arm resets alternating selector to hold
// (RULE9) Load TC toggles; second load does not
// (RULE10) Load-and-arm equals load then arm
// (RULE11) Arm half re-enables after disarming TC
// (RULE12) Load-and-arm forces next reload from hold
// (RULE13) Host avoids load-and-arm when asynchronous
// (RULE14) Disarm waits one count in TC
// (RULE15) Save copies count into hold
// (RULE16) Disarm-and-save is disarm then save
// (RULE17) Set-toggle drives toggle high
// (RULE18) Clear-toggle drives toggle low
// (RULE19) Toggle reaches pin in mode 010
// (RULE20) Step counts by one, even disarmed
// (RULE21) Pointer load copies fields, sets byte bit
// (RULE22) Group codes 000 and 110 refused
// (RULE23) Sequencing-disable bit set and cleared
// (RULE24) Wide bus bit set
// (RULE25) Wide bus bit cleared
// (RULE26) Master reset clears registers, modes 0800
// (RULE27) Undefined codes are ignored
`timescale 1ns/1ps
`default_nettype none

module counter_command_decoder
   import cmd_decoder_pkg::*;
#(
   parameter int unsigned N = NUM_COUNTERS,
   parameter int unsigned W = CNT_W
) (
   // Clock and reset
   input  wire logic           ref_clk,
   input  wire logic           rst_b,
   // Command port
   input  wire logic           cmd_wr,
   input  wire logic [7:0]     cmd_byte,
   // Per-counter configuration from the mode decode
   input  wire reload_class_t  rclass    [N],
   input  wire logic [N-1:0]   disarm_on_tc,
   input  wire logic [N-1:0]   use_hold,
   input  wire logic [N-1:0]   gate_level,
   input  wire logic [N-1:0]   src_edge,
   input  wire logic [N*W-1:0] load_vals,
   // Counter state
   output logic [N*W-1:0]      count_vals,
   output logic [N*W-1:0]      hold_vals,
   output logic [N-1:0]        armed,
   output logic [N-1:0]        terminal_count_state,
   output logic [N-1:0]        count_out,
   // Mode registers
   output logic [N*16-1:0]     mode_vals,
   output logic [15:0]         master_mode,
   output logic                pointer_sequencing_disable,
   output logic                wide_bus_select,
   output data_ptr_t           data_ptr
);

   ////////////////////////////////////////////////////////////////////////
   // Reset release
   logic rst_s1_r;
   logic rst_n;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode
   logic [2:0]   op;
   logic [4:0]   op5;
   logic [4:0]   counter_select_mask;
   logic [2:0]   counter_index;
   logic [1:0]   element_field;
   logic [2:0]   group_field;
   logic         idx_ok;
   logic [N-1:0] idx_hot;
   logic [N-1:0] mask_sel;

   assign op                  = cmd_byte[7:5];
   assign op5                 = cmd_byte[7:3];
   assign counter_select_mask = cmd_byte[4:0];
   assign counter_index       = cmd_byte[2:0];
   assign element_field       = cmd_byte[4:3];
   assign group_field         = cmd_byte[2:0];

   // (RULE1) Mask selects counters
   assign mask_sel = cmd_wr ? counter_select_mask[N-1:0] : '0;

   // (RULE27) Index 0, 6, 7 strobe no counter
   assign idx_ok  = (counter_index != 3'h0) && (counter_index <= 3'h5);
   assign idx_hot = idx_ok ? N'(1 << (counter_index - 3'h1)) : '0;

   logic is_load;
   logic is_arm;
   logic is_disarm;
   logic is_save;
   logic is_step;
   logic is_set_tog;
   logic is_clr_tog;
   logic is_mreset;
   logic is_ptr;

   // (RULE10) Load-and-arm both halves
   assign is_load   = (op == OP_LOAD) || (op == OP_LOAD_ARM);
   // (RULE2) Arm only sets
   assign is_arm    = (op == OP_ARM) || (op == OP_LOAD_ARM);
   // (RULE16) Disarm-and-save both halves
   assign is_disarm = (op == OP_DISARM) || (op == OP_DISARM_SV);
   assign is_save   = (op == OP_SAVE) || (op == OP_DISARM_SV);

   assign is_mreset = cmd_wr && (cmd_byte == CMD_MASTER_RST);

   // Whole-byte master-mode codes share the toggle opcodes with index 0
   // or 7, so idx_ok keeps them apart.
   assign is_set_tog = cmd_wr && (op5 == OP_SET_TOGGLE) && idx_ok;
   assign is_clr_tog = cmd_wr && (op5 == OP_CLR_TOGGLE) && idx_ok;
   assign is_step    = cmd_wr && (op5 == OP_STEP) && idx_ok;

   // (RULE22) Refuse bad group codes
   assign is_ptr = cmd_wr && (op == OP_LOAD_PTR)
                   && (group_field != GRP_BAD_A)
                   && (group_field != GRP_BAD_B);

   ////////////////////////////////////////////////////////////////////////
   // Master mode and data pointer
   logic [15:0] master_r;
   logic [15:0] master_nxt;
   data_ptr_t   ptr_r;

   always_comb begin
      master_nxt = master_r;
      if (cmd_wr) begin
         unique case (cmd_byte)
            // (RULE23) Sequencing bit only
            CMD_SEQ_DIS:    master_nxt[MM_SEQ_DIS_BIT] = 1'b1;
            CMD_SEQ_EN:     master_nxt[MM_SEQ_DIS_BIT] = 1'b0;
            // (RULE24) Wide bus set
            CMD_WIDE_SET:   master_nxt[MM_WIDE_BIT] = 1'b1;
            // (RULE25) Byte-wide bus
            CMD_WIDE_CLR:   master_nxt[MM_WIDE_BIT] = 1'b0;
            // (RULE26) Master mode cleared
            CMD_MASTER_RST: master_nxt = MASTER_RST_VAL;
            default:        master_nxt = master_r;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         master_r <= MASTER_RST_VAL;
      else
         master_r <= master_nxt;
   end

   // Master reset leaves the pointer alone on purpose
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         ptr_r <= '0;
      else if (is_ptr)
         // (RULE21) Copy fields, set byte bit
         ptr_r <= '{byte_ptr: 1'b1, element_field: element_field,
                    group_field: group_field};
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter-mode registers; only master reset writes them here
   logic [N*16-1:0] mode_r;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         mode_r <= {N{MODE_RST_VAL}};
      else if (is_mreset)
         mode_r <= {N{MODE_RST_VAL}};
   end

   ////////////////////////////////////////////////////////////////////////
   // Counters
   logic [N-1:0] tog_pin;

   for (genvar i = 0; i < N; i++) begin : g_cnt
      cnt_cfg_t cfg;
      cnt_cmd_t cmd;
      logic     msel;

      assign msel = mask_sel[i];
      assign cfg  = '{mode: mode_r[i*16 +: 16], rclass: rclass[i],
                      disarm_on_tc: disarm_on_tc[i],
                      gate_level: gate_level[i], use_hold: use_hold[i]};
      assign cmd  = '{load:    msel && is_load,
                      arm:     msel && is_arm,
                      disarm:  msel && is_disarm,
                      save:    msel && is_save,
                      step:    is_step && idx_hot[i],
                      set_tog: is_set_tog && idx_hot[i],
                      clr_tog: is_clr_tog && idx_hot[i],
                      mreset:  is_mreset};

      counter_slice #(.W(W)) u_cnt (
         .clk      (ref_clk),
         .rst_n    (rst_n),
         .cfg      (cfg),
         .cmd      (cmd),
         .load_val (is_mreset ? '0 : load_vals[i*W +: W]),
         .src_edge (src_edge[i]),
         .count_r  (count_vals[i*W +: W]),
         .hold_r   (hold_vals[i*W +: W]),
         .armed_r  (armed[i]),
         .tc_r     (terminal_count_state[i]),
         .toggle_r (),
         .out_r    (tog_pin[i])
      );
   end

   assign count_out                  = tog_pin;
   assign mode_vals                  = mode_r;
   assign master_mode                = master_r;
   assign pointer_sequencing_disable = master_r[MM_SEQ_DIS_BIT];
   assign wide_bus_select            = master_r[MM_WIDE_BIT];
   assign data_ptr                   = ptr_r;

endmodule

`default_nettype wire

/* src/cmd_decoder_pkg.sv */
/*
   Shared constants and types for the counter command decoder.
   Assumes a five-counter timing controller with 16-bit counters.
*/
package cmd_decoder_pkg;

   localparam int unsigned NUM_COUNTERS = 5;
   localparam int unsigned CNT_W        = 16;

   // Upper three command bits for the mask-type and pointer commands
   localparam logic [2:0] OP_LOAD_PTR   = 3'h0;
   localparam logic [2:0] OP_ARM        = 3'h1;
   localparam logic [2:0] OP_LOAD       = 3'h2;
   localparam logic [2:0] OP_LOAD_ARM   = 3'h3;
   localparam logic [2:0] OP_DISARM_SV  = 3'h4;
   localparam logic [2:0] OP_SAVE       = 3'h5;
   localparam logic [2:0] OP_DISARM     = 3'h6;
   localparam logic [2:0] OP_EXTENDED   = 3'h7;

   // Upper five bits for the index-type commands
   localparam logic [4:0] OP_CLR_TOGGLE = 5'h1c;
   localparam logic [4:0] OP_SET_TOGGLE = 5'h1d;
   localparam logic [4:0] OP_STEP       = 5'h1e;

   // Whole-byte master-mode commands
   localparam logic [7:0] CMD_SEQ_DIS   = 8'he8;
   localparam logic [7:0] CMD_SEQ_EN    = 8'he0;
   localparam logic [7:0] CMD_WIDE_SET  = 8'hef;
   localparam logic [7:0] CMD_WIDE_CLR  = 8'he7;
   localparam logic [7:0] CMD_MASTER_RST = 8'hff;

   // Group codes that the pointer load refuses
   localparam logic [2:0] GRP_BAD_A     = 3'h0;
   localparam logic [2:0] GRP_BAD_B     = 3'h6;

   // Reset values
   localparam logic [15:0] MASTER_RST_VAL = 16'h0000;
   localparam logic [15:0] DATA_RST_VAL   = 16'h0000;
   localparam logic [15:0] MODE_RST_VAL   = 16'h0800;

   // Counter-mode field positions
   localparam int unsigned MODE_DIR_BIT  = 3;
   localparam int unsigned MODE_OUT_LSB  = 0;
   localparam logic [2:0]  OUT_TOGGLED   = 3'h2;

   // Master-mode bit positions
   localparam int unsigned MM_SEQ_DIS_BIT = 14;
   localparam int unsigned MM_WIDE_BIT    = 13;

   // Reload behaviour class, derived outside from the full mode decode
   typedef enum logic [1:0] {
      RL_PLAIN     = 2'b00,
      RL_ALTERNATE = 2'b01,
      RL_GATE_SEL  = 2'b10
   } reload_class_t;

   // Per-counter static configuration
   typedef struct packed {
      logic [15:0]   mode;
      reload_class_t rclass;
      logic          disarm_on_tc;
      logic          gate_level;
      logic          use_hold;
   } cnt_cfg_t;

   // Per-counter command strobes sent to the counter slice
   typedef struct packed {
      logic load;
      logic arm;
      logic disarm;
      logic save;
      logic step;
      logic set_tog;
      logic clr_tog;
      logic mreset;
   } cnt_cmd_t;

   // Data pointer contents
   typedef struct packed {
      logic       byte_ptr;
      logic [1:0] element_field;
      logic [2:0] group_field;
   } data_ptr_t;

endpackage

/* src/counter_slice.sv */
/*
   One counter of the timing controller: value and hold registers, reload mux,
   arm state, terminal count state, reload selector and toggle flip-flop.
   Assumes its command strobes are one-cycle pulses from the decoder.
*/
`timescale 1ns/1ps
`default_nettype none

module counter_slice
   import cmd_decoder_pkg::*;
#(
   parameter int unsigned W = CNT_W
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Configuration and commands
   input  wire cnt_cfg_t     cfg,
   input  wire cnt_cmd_t     cmd,
   input  wire logic [W-1:0] load_val,
   input  wire logic         src_edge,
   // State
   output logic [W-1:0]      count_r,
   output logic [W-1:0]      hold_r,
   output logic              armed_r,
   output logic              tc_r,
   output logic              toggle_r,
   output logic              out_r
);

   logic         disarm_pend_r;
   logic         next_hold_r;
   logic         pseudo;
   logic         cnt_pulse;
   logic         at_end;
   logic         reach_tc;
   logic         plan_hold;
   logic         alt;
   logic [W-1:0] reload_val;
   logic [W-1:0] stepped;

   assign alt = (cfg.rclass == RL_ALTERNATE);
   assign at_end = (count_r == {{(W-1){1'b0}}, 1'b1});

   // (RULE7) Gate picks source
   // (RULE6) Disarmed uses load outside gate class
   assign plan_hold = (cfg.rclass == RL_GATE_SEL) ? cfg.gate_level :
                      alt ? (armed_r && next_hold_r) :
                      (armed_r && cfg.use_hold);

   assign reload_val = plan_hold ? hold_r : load_val;
   assign stepped    = cfg.mode[MODE_DIR_BIT] ? count_r + 1'b1
                                              : count_r - 1'b1;

   // (RULE4) Pseudo-count on load
   assign pseudo    = cmd.load;
   assign cnt_pulse = (src_edge && armed_r) || pseudo || cmd.step;
   assign reach_tc  = !tc_r && at_end && (pseudo || cnt_pulse);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r       <= '0;
         hold_r        <= '0;
         armed_r       <= 1'b0;
         tc_r          <= 1'b0;
         toggle_r      <= 1'b0;
         disarm_pend_r <= 1'b0;
         next_hold_r   <= 1'b1;
      end else if (cmd.mreset) begin
         count_r       <= '0;
         hold_r        <= '0;
         armed_r       <= 1'b0;
         tc_r          <= 1'b0;
         disarm_pend_r <= 1'b0;
         next_hold_r   <= 1'b1;
      end else begin
         // (RULE15) Save to hold
         if (cmd.save)
            hold_r <= count_r;
         // (RULE20) Step by one
         if (cmd.step && !reach_tc)
            count_r <= stepped;
         else if (reach_tc || (tc_r && cnt_pulse) || pseudo)
            // (RULE3) Load from source
            count_r <= reload_val;
         else if (cnt_pulse)
            count_r <= stepped;
         // (RULE5) Load ends TC
         if (reach_tc)
            tc_r <= 1'b1;
         else if (tc_r && cnt_pulse)
            tc_r <= 1'b0;
         // (RULE9) Toggle only on TC
         if (alt && reach_tc)
            next_hold_r <= !next_hold_r;
         // (RULE14) Disarm deferred in TC
         if (cmd.disarm && tc_r && !cnt_pulse)
            disarm_pend_r <= 1'b1;
         else if (!tc_r || cnt_pulse)
            disarm_pend_r <= 1'b0;
         // (RULE11) Arm after load wins
         if (cmd.arm) begin
            armed_r <= 1'b1;
            // (RULE8) Arm resets selector
            // (RULE12) Next TC uses hold
            if (alt)
               next_hold_r <= 1'b1;
         end else if ((cmd.disarm && (!tc_r || cnt_pulse))
                      || (disarm_pend_r && tc_r && cnt_pulse)
                      || (cfg.disarm_on_tc && reach_tc))
            armed_r <= 1'b0;
         // (RULE17) Set toggle
         // (RULE18) Clear toggle
         if (cmd.set_tog)
            toggle_r <= 1'b1;
         else if (cmd.clr_tog)
            toggle_r <= 1'b0;
         else if (reach_tc)
            toggle_r <= !toggle_r;
      end
   end

   // (RULE19) Toggle visible in mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         out_r <= 1'b0;
      else
         out_r <= (cfg.mode[MODE_OUT_LSB +: 3] == OUT_TOGGLED) ? toggle_r
                                                              : tc_r;
   end

endmodule

`default_nettype wire

/* tb/cmd_decoder_monitor.sv */
/*
   Port checker for the counter command decoder.
   Assumes it is bound into counter_command_decoder and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none

module cmd_decoder_monitor
   import cmd_decoder_pkg::*;
#(
   parameter int unsigned N = NUM_COUNTERS,
   parameter int unsigned W = CNT_W
) (
   // Clock, reset and command port
   input wire logic         ref_clk,
   input wire logic         rst_b,
   input wire logic         cmd_wr,
   input wire logic [7:0]   cmd_byte,
   input wire logic [N-1:0] src_edge,
   // Observed state
   input wire logic [N*W-1:0]  count_vals,
   input wire logic [N*W-1:0]  hold_vals,
   input wire logic [N-1:0]    armed,
   input wire logic [N-1:0]    terminal_count_state,
   input wire logic [N*16-1:0] mode_vals,
   input wire logic [15:0]     master_mode,
   input wire logic            pointer_sequencing_disable,
   input wire logic            wide_bus_select,
   input wire data_ptr_t       data_ptr
);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   logic [2:0]     op;
   logic           wr_ptr;
   logic           bad_g;
   logic [N*W-1:0] sel_w;
   assign op     = cmd_byte[7:5];
   assign wr_ptr = cmd_wr && op == OP_LOAD_PTR;
   assign bad_g  = cmd_byte[2:0] == GRP_BAD_A || cmd_byte[2:0] == GRP_BAD_B;
   // Widen the mask to one field per counter
   always_comb begin
      for (int i = 0; i < N; i++) begin
         sel_w[i*W +: W] = {W{cmd_byte[i]}};
      end
   end

   chk_ptr_load: assert property (
      wr_ptr && !bad_g |=> data_ptr == {1'b1, $past(cmd_byte[4:0])})
      else $error("pointer load wrong");
   chk_ptr_refuse: assert property (
      wr_ptr && bad_g |=> $stable(data_ptr))
      else $error("bad group changed pointer");
   chk_seq_set: assert property (
      cmd_wr && cmd_byte == CMD_SEQ_DIS |=> pointer_sequencing_disable
      && master_mode[MM_SEQ_DIS_BIT] && $stable(wide_bus_select))
      else $error("sequencing disable not set");
   chk_seq_clr: assert property (
      cmd_wr && cmd_byte == CMD_SEQ_EN |=> !pointer_sequencing_disable
      && $stable(wide_bus_select))
      else $error("sequencing disable not cleared");
   chk_wide_set: assert property (
      cmd_wr && cmd_byte == CMD_WIDE_SET |=> wide_bus_select
      && master_mode[MM_WIDE_BIT] && $stable(pointer_sequencing_disable))
      else $error("wide bus not set");
   chk_wide_clr: assert property (
      cmd_wr && cmd_byte == CMD_WIDE_CLR |=> !wide_bus_select
      && $stable(pointer_sequencing_disable))
      else $error("wide bus not cleared");
   chk_arm_sel: assert property (
      cmd_wr && op == OP_ARM |=>
      (armed & $past(cmd_byte[N-1:0])) == $past(cmd_byte[N-1:0]))
      else $error("selected counter not armed");
   chk_save_hold: assert property (
      cmd_wr && op == OP_SAVE |=>
      (hold_vals & $past(sel_w)) == ($past(count_vals) & $past(sel_w)))
      else $error("save did not copy count");
   chk_mreset_all: assert property (
      cmd_wr && cmd_byte == CMD_MASTER_RST |=> armed == '0
      && master_mode == MASTER_RST_VAL && hold_vals == '0
      && mode_vals == {N{MODE_RST_VAL}})
      else $error("master reset incomplete");
   chk_undef_ignored: assert property (
      cmd_wr && cmd_byte inside {8'hf0, 8'hf6, 8'hf7} && src_edge == '0
      |=> $stable(armed) && $stable(master_mode) && $stable(count_vals))
      else $error("unused code changed state");
   chk_step_one: assert property (
      cmd_wr && cmd_byte == {OP_STEP, 3'h1} && !terminal_count_state[0]
      && !src_edge[0] && count_vals[W-1:0] > W'(2) |=>
      count_vals[W-1:0] == $past(count_vals[W-1:0])
      + ($past(mode_vals[MODE_DIR_BIT]) ? W'(1) : '1))
      else $error("step not by one");

   cp_bad_group: cover property (wr_ptr && bad_g);
   cp_step: cover property (cmd_wr && cmd_byte == {OP_STEP, 3'h1});
   cp_mreset: cover property (cmd_wr && cmd_byte == CMD_MASTER_RST);

endmodule

bind counter_command_decoder cmd_decoder_monitor #(.N(N), .W(W))
   u_cmd_decoder_monitor (.ref_clk, .rst_b, .cmd_wr, .cmd_byte,
   .src_edge, .count_vals, .hold_vals, .armed, .terminal_count_state,
   .mode_vals, .master_mode, .pointer_sequencing_disable,
   .wide_bus_select, .data_ptr);

`default_nettype wire

/* tb/host_cmd_model.sv */
/*
   Host side of the command port: turns a bench request into a strobe.
   Assumes requests come synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module host_cmd_model (
   // Clock and bench request
   input wire logic       ref_clk,
   input wire logic       req,
   input wire logic [7:0] req_byte,
   // Command port
   output logic           cmd_wr,
   output logic [7:0]     cmd_byte
);

   initial begin
      cmd_wr   = 1'b0;
      cmd_byte = 8'h5a;
   end
   // synchronous writes only
   // Idle byte flips each cycle so a stale code never looks valid
   always @(posedge ref_clk) begin
      cmd_wr   <= req;
      cmd_byte <= req ? req_byte : ~cmd_byte;
   end

endmodule

`default_nettype wire

/* tb/counter_command_decoder_test.sv */
/*
   Self-checking bench for the counter command decoder.
   Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %0t got %h want %h", $time, g, e); end end

module counter_command_decoder_test
   import cmd_decoder_pkg::*;
;

   logic          ref_clk = 1'b0;
   logic          rst_b   = 1'b0;
   logic          req     = 1'b0;
   logic [7:0]    rb      = 8'h00;
   logic [4:0]    uh      = 5'h00;
   reload_class_t rcl [5] = '{default: RL_PLAIN};
   logic [79:0]   lv = {16'h5005, 16'h4004, 16'h3003, 16'h2002, 16'h1001};
   logic          cmd_wr;
   logic [7:0]    cmd_byte;
   logic [4:0]    armed, tcs, cout;
   logic [79:0]   count_vals, hold_vals, mode_vals;
   logic [15:0]   master_mode;
   logic          psd, wide;
   data_ptr_t     data_ptr, ptr_keep;
   int            n_fail = 0;
   int            n_checks = 0;

   always #5 ref_clk = ~ref_clk;

   host_cmd_model u_host_cmd_model (.ref_clk, .req, .req_byte(rb),
      .cmd_wr, .cmd_byte);

   counter_command_decoder u_counter_command_decoder (.ref_clk, .rst_b,
      .cmd_wr, .cmd_byte, .rclass(rcl), .disarm_on_tc(5'h00), .use_hold(uh),
      .gate_level(5'h00), .src_edge(5'h00), .load_vals(lv), .count_vals,
      .hold_vals, .armed, .terminal_count_state(tcs), .count_out(cout),
      .mode_vals, .master_mode, .pointer_sequencing_disable(psd),
      .wide_bus_select(wide), .data_ptr);

   function automatic logic [15:0] cv(input int i);
      return count_vals[i*16 +: 16];
   endfunction
   function automatic logic [15:0] hv(input int i);
      return hold_vals[i*16 +: 16];
   endfunction

   // Effects land one edge after the strobe is taken
   task automatic send(input logic [7:0] b);
      @(posedge ref_clk);
      req <= 1'b1;
      rb  <= b;
      @(posedge ref_clk);
      req <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic t_reset;
      `CHK(mode_vals, {5{MODE_RST_VAL}})
      `CHK(master_mode, MASTER_RST_VAL)
      `CHK(armed, 5'h00)
      $display("test reset done");
   endtask

   task automatic t_pointer;
      data_ptr_t exp;
      exp = '0;
      for (int g = 0; g < 8; g++) begin
         if (g != 0 && g != 6) begin
            exp = {1'b1, 2'(g), 3'(g)};
         end
         send({3'h0, 2'(g), 3'(g)});
         `CHK(data_ptr, exp)
      end
      $display("test pointer done");
   endtask

   task automatic mm(input logic [7:0] b, input logic p, input logic w);
      send(b);
      `CHK({psd, wide}, {p, w})
      `CHK(master_mode, {1'b0, p, w, 13'h0000})
   endtask

   task automatic t_master;
      mm(8'he8, 1'b1, 1'b0);
      mm(8'hef, 1'b1, 1'b1);
      mm(8'hf0, 1'b1, 1'b1);
      mm(8'hf6, 1'b1, 1'b1);
      mm(8'hf7, 1'b1, 1'b1);
      mm(8'he0, 1'b0, 1'b1);
      mm(8'he7, 1'b0, 1'b0);
      $display("test master done");
   endtask

   task automatic t_counters;
      send(8'h45);
      `CHK({cv(0), cv(1), cv(2)}, {16'h1001, 16'h0000, 16'h3003})
      send(8'hf1);
      `CHK(cv(0), 16'h1000)
      send(8'ha1);
      `CHK(hv(0), 16'h1000)
      send(8'hf1);
      send(8'h21);
      `CHK(armed, 5'h01)
      @(posedge ref_clk);
      uh <= 5'h01;
      send(8'h41);
      `CHK(cv(0), 16'h1000)
      send(8'h24);
      `CHK(armed, 5'h05)
      send(8'hc1);
      `CHK(armed, 5'h04)
      send(8'h41);
      `CHK(cv(0), 16'h1001)
      send(8'h78);
      `CHK({armed, cv(3), cv(4)}, {5'h1c, 16'h4004, 16'h5005})
      send(8'h88);
      `CHK({armed, hv(3)}, {5'h14, 16'h4004})
      $display("test counters done");
   endtask

   task automatic t_toggle;
      send(8'he9);
      @(posedge ref_clk);
      #1;
      `CHK(cout, tcs)
      $display("test toggle done");
   endtask

   task automatic t_mreset;
      ptr_keep = data_ptr;
      send(8'hff);
      `CHK({armed, hold_vals}, {5'h00, 80'h0})
      `CHK(mode_vals, {5{MODE_RST_VAL}})
      `CHK(data_ptr, ptr_keep)
      $display("test master reset done");
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      t_reset();
      t_pointer();
      t_master();
      t_counters();
      t_toggle();
      t_mreset();
      final_report();
   end

   // A hung run counts as a mismatch
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_fail++;
      final_report();
   end

endmodule

`default_nettype wire
